//--- src/matrix_scan_mapping_config.sv
// display RAM access, command decode and common/segment scan mapping
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "scan_map_defs.svh"
module matrix_scan_mapping_config #(
   parameter int COLS = 120,
   parameter int ROWS = 128
) (
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic [1:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   output scan_map_pkg::scan_t scan_out,
   output logic common_oe_out,
   output logic seg_enable_out,
   output logic regulator_internal_out
);
   import scan_map_pkg::*;

   logic [15:0] display_ram [ROWS][COLS];

   cfg_t cfg_ff, nxt_cfg;
   cmd_st_t cst_ff, nxt_cst;
   mem_st_t mem_ff, nxt_mem;
   logic [7:0] cmd_ff, nxt_cmd;
   logic [7:0] arg_ff, nxt_arg;
   logic [7:0] hi_ff, nxt_hi;
   logic half_ff, nxt_half;
   logic [6:0] col_ptr_ff, nxt_col_ptr;
   logic [6:0] row_ptr_ff, nxt_row_ptr;
   logic [6:0] col_start_ff, nxt_col_start;
   logic [6:0] col_end_ff, nxt_col_end;
   logic [6:0] row_start_ff, nxt_row_start;
   logic [6:0] row_end_ff, nxt_row_end;
   logic wr_cmd, wr_dat, rd_dat, ram_we, step;
   logic [15:0] ram_wdata;

   // nibble order reversal, used the same way on write and read
   function automatic logic [15:0] nib_map(input logic [15:0] w, input logic rm);
      nib_map = rm ? {w[3:0], w[7:4], w[11:8], w[15:12]} : w;
   endfunction

   // gray level shown for each of the four pixels of a word
   function automatic logic [15:0] shade(input logic [15:0] w, input disp_mode_t m);
      logic [15:0] r;
      r = w;
      for (int i = 0; i < 4; i++) begin
         case (m)
            D_ALL_ON: r[i*4 +: 4] = 4'hf;
            D_ALL_OFF: r[i*4 +: 4] = 4'h0;
            D_INVERSE: r[i*4 +: 4] = 4'hf - w[i*4 +: 4];
            default: r[i*4 +: 4] = w[i*4 +: 4];
         endcase
      end
      return r;
   endfunction

   assign wr_cmd = wr_in && (addr_in == `OFF_CMD);
   assign wr_dat = wr_in && (addr_in == `OFF_DATA);
   assign rd_dat = rd_in && (addr_in == `OFF_DATA);

   always_comb begin
      nxt_cfg = cfg_ff;
      nxt_cst = cst_ff;
      nxt_mem = mem_ff;
      nxt_cmd = cmd_ff;
      nxt_arg = arg_ff;
      nxt_hi = hi_ff;
      nxt_half = half_ff;
      nxt_col_ptr = col_ptr_ff;
      nxt_row_ptr = row_ptr_ff;
      nxt_col_start = col_start_ff;
      nxt_col_end = col_end_ff;
      nxt_row_start = row_start_ff;
      nxt_row_end = row_end_ff;
      ram_we = 1'b0;
      step = 1'b0;
      ram_wdata = nib_map({hi_ff, wdata_in}, cfg_ff.nib_remap);
      if (wr_cmd) begin
         nxt_cmd = wdata_in;
         nxt_mem = M_NONE;
         nxt_half = 1'b0;
         nxt_cst = C_IDLE;
         case (wdata_in)
            `CMD_WRAM: nxt_mem = M_WRITE;
            `CMD_RRAM: nxt_mem = M_READ;
            `CMD_NORM: nxt_cfg.mode = D_NORMAL;
            `CMD_ALLON: nxt_cfg.mode = D_ALL_ON;
            `CMD_ALLOFF: nxt_cfg.mode = D_ALL_OFF;
            `CMD_INV: nxt_cfg.mode = D_INVERSE;
            `CMD_NOPART: nxt_cfg.partial = 1'b0;
            `CMD_OFF: nxt_cfg.panel_on = 1'b0;
            `CMD_ON: nxt_cfg.panel_on = 1'b1;
            `CMD_COL, `CMD_ROW, `CMD_REMAP, `CMD_START, `CMD_OFFS,
            `CMD_PART, `CMD_FUNC, `CMD_PHASE, `CMD_MUX: nxt_cst = C_ARG1;
            default: nxt_cst = C_IDLE;
         endcase
      end else if (wr_dat && cst_ff == C_ARG1) begin
         nxt_arg = wdata_in;
         nxt_cst = C_IDLE;
         case (cmd_ff)
            `CMD_COL, `CMD_ROW, `CMD_REMAP, `CMD_PART: nxt_cst = C_ARG2;
            `CMD_START: nxt_cfg.start_line = wdata_in[6:0];
            `CMD_OFFS: nxt_cfg.offset = wdata_in[6:0];
            `CMD_FUNC: nxt_cfg.reg_internal = wdata_in[0];
            `CMD_PHASE: nxt_cfg.phase = wdata_in;
            `CMD_MUX: nxt_cfg.multiplex_ratio = wdata_in[6:0];
            default: nxt_cst = C_IDLE;
         endcase
      end else if (wr_dat && cst_ff == C_ARG2) begin
         nxt_cst = C_IDLE;
         case (cmd_ff)
            `CMD_COL: begin
               nxt_col_start = arg_ff[6:0];
               nxt_col_end = wdata_in[6:0];
               nxt_col_ptr = arg_ff[6:0];
            end
            `CMD_ROW: begin
               nxt_row_start = arg_ff[6:0];
               nxt_row_end = wdata_in[6:0];
               nxt_row_ptr = arg_ff[6:0];
            end
            `CMD_REMAP: begin
               nxt_cfg.incr_vert = arg_ff[`BIT_INCR];
               nxt_cfg.col_remap = arg_ff[`BIT_CREMAP];
               nxt_cfg.nib_remap = arg_ff[`BIT_NREMAP];
               nxt_cfg.scan_up = arg_ff[`BIT_DIR];
               nxt_cfg.split = arg_ff[`BIT_SPLIT];
               nxt_cfg.dual = wdata_in[`BIT_DUAL];
            end
            `CMD_PART: begin
               nxt_cfg.partial = 1'b1;
               nxt_cfg.part_start = arg_ff[6:0];
               nxt_cfg.part_end = wdata_in[6:0];
            end
            default: nxt_cst = C_IDLE;
         endcase
      end else if (wr_dat && mem_ff == M_WRITE) begin
         nxt_half = ~half_ff;
         nxt_hi = wdata_in;
         ram_we = half_ff;
         step = half_ff;
      end else if (rd_dat && mem_ff == M_READ) begin
         nxt_half = ~half_ff;
         step = half_ff;
      end
      if (step) begin
         if (!cfg_ff.incr_vert) begin
            if (col_ptr_ff == col_end_ff) begin
               nxt_col_ptr = col_start_ff;
               nxt_row_ptr = (row_ptr_ff == row_end_ff) ? row_start_ff : row_ptr_ff + 7'h01;
            end else begin
               nxt_col_ptr = col_ptr_ff + 7'h01;
            end
         end else begin
            if (row_ptr_ff == row_end_ff) begin
               nxt_row_ptr = row_start_ff;
               nxt_col_ptr = (col_ptr_ff == col_end_ff) ? col_start_ff : col_ptr_ff + 7'h01;
            end else begin
               nxt_row_ptr = row_ptr_ff + 7'h01;
            end
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         cfg_ff <= '0;
         cfg_ff.multiplex_ratio <= `RST_MUX;
         cfg_ff.phase <= `RST_PHASE;
         cst_ff <= C_IDLE;
         mem_ff <= M_NONE;
         cmd_ff <= 8'h00;
         arg_ff <= 8'h00;
         hi_ff <= 8'h00;
         half_ff <= 1'b0;
         col_ptr_ff <= 7'h00;
         row_ptr_ff <= 7'h00;
         col_start_ff <= 7'h00;
         col_end_ff <= `RST_COL_END;
         row_start_ff <= 7'h00;
         row_end_ff <= `RST_ROW_END;
      end else begin
         cfg_ff <= nxt_cfg;
         cst_ff <= nxt_cst;
         mem_ff <= nxt_mem;
         cmd_ff <= nxt_cmd;
         arg_ff <= nxt_arg;
         hi_ff <= nxt_hi;
         half_ff <= nxt_half;
         col_ptr_ff <= nxt_col_ptr;
         row_ptr_ff <= nxt_row_ptr;
         col_start_ff <= nxt_col_start;
         col_end_ff <= nxt_col_end;
         row_start_ff <= nxt_row_start;
         row_end_ff <= nxt_row_end;
      end
   end

   // memory port: word write, host read byte, scan fetch
   logic [15:0] rd_word;
   assign rd_word = nib_map(display_ram[row_ptr_ff][col_ptr_ff], cfg_ff.nib_remap);

   always_ff @(posedge mclk_in) begin
      if (ram_we) begin
         display_ram[row_ptr_ff][col_ptr_ff] <= ram_wdata;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         rdata_out <= 8'h00;
      end else if (rd_dat && mem_ff == M_READ) begin
         rdata_out <= half_ff ? rd_word[7:0] : rd_word[15:8];
      end else if (rd_in && addr_in == `OFF_STAT) begin
         rdata_out <= {cfg_ff.panel_on, cfg_ff.partial, cfg_ff.mode,
                       half_ff, mem_ff == M_READ, mem_ff == M_WRITE, cst_ff != C_IDLE};
      end else begin
         rdata_out <= 8'h00;
      end
   end

   // scan engine, one display clock tick per clock
   scan_st_t sst_ff, nxt_sst;
   logic [6:0] line_ff, nxt_line;
   logic [6:0] col_ff, nxt_col;
   logic [7:0] cnt_ff, nxt_cnt;
   logic [7:0] ph1_len, ph2_len;
   logic [6:0] com_log, row_sel, pin;
   logic in_part;

   assign ph1_len = {cfg_ff.phase[3:0], 1'b0};
   assign ph2_len = {4'h0, cfg_ff.phase[7:4]};

   always_comb begin
      nxt_sst = sst_ff;
      nxt_line = line_ff;
      nxt_col = col_ff;
      nxt_cnt = cnt_ff + 8'h01;
      case (sst_ff)
         S_PH1: begin
            if (cnt_ff + 8'h01 >= ph1_len) begin
               nxt_sst = S_PH2;
               nxt_cnt = 8'h00;
            end
         end
         S_PH2: begin
            if (cnt_ff + 8'h01 >= ph2_len) begin
               nxt_sst = S_DRV;
               nxt_cnt = 8'h00;
               nxt_col = 7'h00;
            end
         end
         S_DRV: begin
            nxt_cnt = 8'h00;
            if (col_ff == 7'(COLS - 1)) begin
               nxt_sst = S_PH1;
               nxt_line = (line_ff >= cfg_ff.multiplex_ratio) ? 7'h00 : line_ff + 7'h01;
            end else begin
               nxt_col = col_ff + 7'h01;
            end
         end
         default: nxt_sst = S_PH1;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         sst_ff <= S_PH1;
         line_ff <= 7'h00;
         col_ff <= 7'h00;
         cnt_ff <= 8'h00;
      end else begin
         sst_ff <= nxt_sst;
         line_ff <= nxt_line;
         col_ff <= nxt_col;
         cnt_ff <= nxt_cnt;
      end
   end

   // logical common index, then row and physical pin
   assign com_log = cfg_ff.scan_up ? 7'h7f - line_ff : line_ff;
   assign row_sel = line_ff + cfg_ff.start_line + cfg_ff.offset;
   assign pin = cfg_ff.split ? {com_log[0], com_log[6:1]} : com_log;
   assign in_part = !cfg_ff.partial ||
                    (row_sel >= cfg_ff.part_start && row_sel <= cfg_ff.part_end);

   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         scan_out <= '0;
         common_oe_out <= 1'b0;
         seg_enable_out <= 1'b0;
         regulator_internal_out <= 1'b0;
      end else begin
         scan_out.common_output <= pin;
         scan_out.common_output_dual <= pin + 7'h40;
         scan_out.dual_active <= cfg_ff.dual;
         scan_out.common_drive <= cfg_ff.panel_on && in_part;
         scan_out.row <= row_sel;
         scan_out.seg_group <= cfg_ff.col_remap ? 7'(COLS - 1) - col_ff : col_ff;
         scan_out.levels <= (cfg_ff.panel_on && in_part) ?
                            shade(display_ram[row_sel][col_ff], cfg_ff.mode) : 16'h0000;
         scan_out.valid <= (sst_ff == S_DRV);
         common_oe_out <= cfg_ff.panel_on && in_part;
         seg_enable_out <= cfg_ff.panel_on;
         regulator_internal_out <= cfg_ff.reg_internal;
      end
   end
endmodule // matrix_scan_mapping_config

//--- inc/scan_map_defs.svh
// constants of the display scan, mapping and configuration block
// How it works
// - horizontal mode: column pointer steps, wraps to start, then row steps.
// - vertical mode: row pointer steps, wraps to start, then column steps.
// - column remap reverses column to segment group order, four segments each.
// - nibble remap bit selects direct or reordered nibbles on the data path.
// - scan direction bit scans commons top to bottom or bottom to top.
// - odd/even split puts odd commons on one side and even on the other.
// - dual common bit in second parameter byte enables dual common driving.
// - start line picks the row on the first common, rows wrap modulo 128.
// - seven-bit offset moves the start line toward common zero.
// - normal mode shows RAM gray levels and cancels the other modes.
// - all-on mode shows the highest gray level everywhere.
// - all-off mode shows the lowest gray level everywhere.
// - inverse mode shows level 15 minus the RAM value.
// - partial display command takes a start row and an end row.
// - exit partial command drives the whole multiplexed area again.
// - supply select bit picks internal regulator or external core supply.
// - panel on enables drive; off grounds segments, floats commons.
// - phase one lasts the low nibble times two display clock ticks.
// - phase two lasts the high nibble display clock ticks.
// - setting a window loads its pointer with the window start.
// - after write-RAM every data byte goes to RAM until a new command.
// - multiplex value N gives N plus one commons, reset 127.
`ifndef SCAN_MAP_DEFS_SVH
`define SCAN_MAP_DEFS_SVH
`define OFF_CMD 2'h0
`define OFF_DATA 2'h1
`define OFF_STAT 2'h2
`define CMD_COL 8'h15
`define CMD_WRAM 8'h5c
`define CMD_RRAM 8'h5d
`define CMD_ROW 8'h75
`define CMD_REMAP 8'ha0
`define CMD_START 8'ha1
`define CMD_OFFS 8'ha2
`define CMD_NORM 8'ha4
`define CMD_ALLON 8'ha5
`define CMD_ALLOFF 8'ha6
`define CMD_INV 8'ha7
`define CMD_PART 8'ha8
`define CMD_NOPART 8'ha9
`define CMD_FUNC 8'hab
`define CMD_OFF 8'hae
`define CMD_ON 8'haf
`define CMD_PHASE 8'hb1
`define CMD_MUX 8'hca
`define BIT_INCR 0
`define BIT_CREMAP 1
`define BIT_NREMAP 2
`define BIT_DIR 4
`define BIT_SPLIT 5
`define BIT_DUAL 4
`define RST_MUX 7'h7f
`define RST_COL_END 7'h77
`define RST_ROW_END 7'h7f
`define RST_PHASE 8'h74
`define DRIVE_TICKS 8'h04
`endif

//--- inc/scan_map_pkg.sv
// types shared by the display scan, mapping and configuration block
package scan_map_pkg;
   typedef enum {C_IDLE, C_ARG1, C_ARG2} cmd_st_t;
   typedef enum {M_NONE, M_WRITE, M_READ} mem_st_t;
   typedef enum {S_PH1, S_PH2, S_DRV} scan_st_t;
   typedef enum logic [1:0] {D_NORMAL, D_ALL_ON, D_ALL_OFF, D_INVERSE} disp_mode_t;
   typedef struct packed {
      logic incr_vert;
      logic col_remap;
      logic nib_remap;
      logic scan_up;
      logic split;
      logic dual;
      logic [6:0] start_line;
      logic [6:0] offset;
      disp_mode_t mode;
      logic partial;
      logic [6:0] part_start;
      logic [6:0] part_end;
      logic reg_internal;
      logic panel_on;
      logic [7:0] phase;
      logic [6:0] multiplex_ratio;
   } cfg_t;
   typedef struct packed {
      logic [6:0] common_output;
      logic [6:0] common_output_dual;
      logic dual_active;
      logic common_drive;
      logic [6:0] row;
      logic [6:0] seg_group;
      logic [15:0] levels;
      logic valid;
   } scan_t;
endpackage

//--- testbench/host_model.sv
// host side model issuing command, parameter and data bytes
`timescale 1ns/1ps
module host_model (
   input wire logic mclk_in,
   input wire logic [7:0] rdata_in,
   output logic [1:0] addr_out,
   output logic [7:0] wdata_out,
   output logic wr_out,
   output logic rd_out
);
   initial begin
      addr_out = 2'h0;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   task automatic put(input logic [1:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge mclk_in);
      wr_out <= 1'b0;
      wdata_out <= ~d;
   endtask
   task automatic get(input logic [1:0] a, output logic [7:0] d);
      @(posedge mclk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge mclk_in);
      rd_out <= 1'b0;
      #1 d = rdata_in;
   endtask
endmodule // host_model

//--- testbench/matrix_scan_mapping_config_monitor.sv
// port-level assertions of the scan mapping block
`timescale 1ns/1ps
`include "scan_map_defs.svh"
module matrix_scan_mapping_config_monitor #(
   parameter int COLS = 120
) (
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic [1:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] rdata_out,
   input wire scan_map_pkg::scan_t scan_out,
   input wire logic common_oe_out,
   input wire logic seg_enable_out,
   input wire logic regulator_internal_out
);
   import scan_map_pkg::*;
   logic [7:0] cmd_ff, nxt_cmd, phase_ff, nxt_phase;
   logic [8:0] run_ff, nxt_run, gap_ff, nxt_gap, quiet_ff, nxt_quiet, exp_gap;
   logic sup_ff, nxt_sup, sup_wr, prm_wr;
   assign prm_wr = wr_in && addr_in == `OFF_DATA;
   assign sup_wr = prm_wr && cmd_ff == `CMD_FUNC;
   assign exp_gap = ((phase_ff[3:0] == 4'h0) ? 9'h1 : {4'h0, phase_ff[3:0], 1'b0})
      + ((phase_ff[7:4] == 4'h0) ? 9'h1 : {5'h0, phase_ff[7:4]});
   always_comb begin
      nxt_cmd = (wr_in && addr_in == `OFF_CMD) ? wdata_in : cmd_ff;
      nxt_phase = (prm_wr && cmd_ff == `CMD_PHASE) ? wdata_in : phase_ff;
      nxt_sup = sup_wr ? wdata_in[0] : sup_ff;
      nxt_run = scan_out.valid ? run_ff + 9'h1 : 9'h0;
      nxt_gap = scan_out.valid ? 9'h0 : gap_ff + 9'h1;
      nxt_quiet = wr_in ? 9'h0 : quiet_ff + {8'h0, quiet_ff != 9'h1ff};
      if (!nrst_in) begin
         nxt_cmd = 8'h00;
         nxt_phase = `RST_PHASE;
         nxt_sup = 1'b0;
         nxt_run = 9'h0;
         nxt_gap = 9'h0;
         nxt_quiet = 9'h0;
      end
   end
   always_ff @(posedge mclk_in) begin
      cmd_ff <= nxt_cmd;
      phase_ff <= nxt_phase;
      sup_ff <= nxt_sup;
      run_ff <= nxt_run;
      gap_ff <= nxt_gap;
      quiet_ff <= nxt_quiet;
   end
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!nrst_in);
   a_rdata_quiet: assert property (!rd_in |=> rdata_out == 8'h00)
      else $error("read data not zero outside its slot");
   a_panel_on: assert property (
      wr_in && addr_in == `OFF_CMD && wdata_in == `CMD_ON |-> ##[1:3] seg_enable_out)
      else $error("panel did not turn on");
   a_panel_off: assert property (
      wr_in && addr_in == `OFF_CMD && wdata_in == `CMD_OFF |-> ##[1:3] !seg_enable_out)
      else $error("panel did not turn off");
   a_commons_float: assert property (!seg_enable_out |-> !common_oe_out)
      else $error("commons driven while panel off");
   a_supply_source: assert property (sup_wr |-> ##[1:3] regulator_internal_out == sup_ff)
      else $error("supply select not applied");
   a_line_length: assert property ($fell(scan_out.valid) |-> run_ff == 9'(COLS))
      else $error("drive period length wrong");
   a_phase_gap: assert property (
      $rose(scan_out.valid) && quiet_ff == 9'h1ff |-> gap_ff == exp_gap)
      else $error("phase one plus phase two length wrong");
   a_dual_pin: assert property (
      scan_out.valid |-> scan_out.common_output_dual == scan_out.common_output + 7'h40)
      else $error("dual common pin wrong");
   cover property ($rose(common_oe_out));
   cover property (sup_wr && wdata_in[0]);
   cover property ($rose(scan_out.valid) && quiet_ff == 9'h1ff);
   cover property (scan_out.valid && scan_out.dual_active);
endmodule // matrix_scan_mapping_config_monitor
bind matrix_scan_mapping_config matrix_scan_mapping_config_monitor #(.COLS(COLS)) mon_u (
   .mclk_in(mclk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
   .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .scan_out(scan_out),
   .common_oe_out(common_oe_out), .seg_enable_out(seg_enable_out),
   .regulator_internal_out(regulator_internal_out));

//--- testbench/matrix_scan_mapping_config_bench.sv
// self-checking bench of the scan mapping block with a RAM and pointer model
`timescale 1ns/1ps
module matrix_scan_mapping_config_bench;
   import scan_map_pkg::*;
   logic mclk_in, nrst_in, wr_in, rd_in, common_oe_out, seg_enable_out, reg_out, vp;
   logic [1:0] addr_in;
   logic [7:0] wdata_in, rdata_out, b;
   logic [7:0] phs [3] = '{8'h74, 8'h35, 8'hff};
   logic [15:0] w;
   logic [6:0] ln;
   logic [15:0] mem [int];
   logic [31:0] seed = 32'd45596;
   scan_t scan_out;
   int failures = 0, total_checks = 0, cycles = 0, n;
   int p [2], lo [2], hi [2];
   matrix_scan_mapping_config dut_u (.mclk_in(mclk_in), .nrst_in(nrst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .scan_out(scan_out), .common_oe_out(common_oe_out), .seg_enable_out(seg_enable_out),
      .regulator_internal_out(reg_out));
   host_model host_u (.mclk_in(mclk_in), .rdata_in(rdata_out), .addr_out(addr_in),
      .wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in));
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [15:0] nrev(input logic [15:0] v);
      return {v[3:0], v[7:4], v[11:8], v[15:12]};
   endfunction
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic cmd(input logic [7:0] c, input logic [7:0] a1, input logic [7:0] a2,
      input int np);
      host_u.put(2'h0, c);
      if (np > 0) host_u.put(2'h1, a1);
      if (np > 1) host_u.put(2'h1, a2);
   endtask
   // pointer model: index 0 steps columns first, index 1 steps rows first
   task automatic step(input int i);
      if (p[i] == hi[i]) begin
         p[i] = lo[i];
         p[1 - i] = (p[1 - i] == hi[1 - i]) ? lo[1 - i] : p[1 - i] + 1;
      end else begin
         p[i]++;
      end
   endtask
   task automatic win;
      lo = '{117, 125};
      hi = '{118, 127};
      p = lo;
      cmd(8'h15, 8'd117, 8'd118, 2);
      cmd(8'h75, 8'd125, 8'd127, 2);
   endtask
   task automatic wait_line;
      repeat (300) @(posedge mclk_in);
      for (int i = 0; i < 200 && !scan_out.valid; i++) begin
         @(posedge mclk_in);
         #1;
      end
   endtask
   initial begin
      mclk_in = 1'b0;
      forever #20 mclk_in = ~mclk_in;
   end
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 40000) begin
         failures++;
         $display("MISMATCH timeout expected finished seen running");
         summarize;
      end
   end
   initial begin
      nrst_in = 1'b0;
      repeat (12) @(posedge mclk_in);
      nrst_in <= 1'b1;
      host_u.get(2'h2, b);
      chk("status", 16'h0, b);
      chk("panel", 16'h0, seg_enable_out);
      chk("supply", 16'h0, reg_out);
      for (int k = 0; k < 4; k++) begin
         cmd(8'ha0, {5'h0, k[1], 1'b0, k[0]}, 8'h00, 2);
         win;
         cmd(8'h5c, 8'h00, 8'h00, 0);
         repeat (6) begin
            seed = xorshift(seed);
            w = seed[15:0];
            mem[p[1] * 128 + p[0]] = k[1] ? nrev(w) : w;
            host_u.put(2'h1, w[15:8]);
            host_u.put(2'h1, w[7:0]);
            step(k[0]);
         end
         cmd(8'ha0, {7'h0, !k[0]}, 8'h00, 2);
         win;
         cmd(8'h5d, 8'h00, 8'h00, 0);
         repeat (6) begin
            host_u.get(2'h1, w[15:8]);
            host_u.get(2'h1, w[7:0]);
            chk("ram word", mem[p[1] * 128 + p[0]], w);
            step(!k[0]);
         end
      end
      cmd(8'haf, 8'h00, 8'h00, 0);
      for (int k = 1; k >= 0; k--) begin
         cmd(8'hab, 8'(k), 8'h00, 1);
         repeat (3) @(posedge mclk_in);
         #1 chk("supply", 16'(k), reg_out);
      end
      for (int k = 0; k < 4; k++) begin
         cmd(8'ha4 + 8'(k), 8'h00, 8'h00, 0);
         host_u.get(2'h2, b);
         chk("mode", 16'(k), b[5:4]);
         wait_line;
         if (k == 1 || k == 2) chk("levels", (k == 1) ? 16'hffff : 16'h0, scan_out.levels);
      end
      cmd(8'ha1, 8'h0c, 8'h00, 1);
      cmd(8'ha2, 8'h05, 8'h00, 1);
      cmd(8'ha8, 8'h20, 8'h5f, 2);
      // pass 0 plain, pass 1 reversed scan and columns, pass 2 odd/even split
      for (int k = 0; k < 3; k++) begin
         cmd(8'ha0, {2'h0, k[1], k[0], 2'h0, k[0], 1'b0}, 8'h00, 2);
         vp = 1'b1;
         repeat (4000) begin
            @(posedge mclk_in);
            #1;
            if (scan_out.valid) begin
               chk("commons driven", scan_out.row >= 7'h20 && scan_out.row <= 7'h5f, common_oe_out);
               ln = scan_out.row - 7'd17;
               ln = k[0] ? 7'd127 - ln : ln;
               chk("pin map", k[1] ? {ln[0], ln[6:1]} : ln, scan_out.common_output);
            end
            if (scan_out.valid && !vp) chk("first group", k[0] ? 16'd119 : 16'd0, scan_out.seg_group);
            vp = scan_out.valid;
         end
      end
      cmd(8'ha9, 8'h00, 8'h00, 0);
      host_u.get(2'h2, b);
      chk("partial flag", 16'h0, b[6]);
      wait_line;
      chk("full area", 16'h1, common_oe_out);
      // sixteen lines with dual commons, split kept off as the host must
      cmd(8'hca, 8'h0f, 8'h00, 1);
      cmd(8'ha0, 8'h00, 8'h10, 2);
      wait_line;
      n = 0;
      repeat (2500) begin
         @(posedge mclk_in);
         #1;
         if (scan_out.valid) begin
            chk("dual active", 16'h1, scan_out.dual_active);
            if (scan_out.common_output > n) n = scan_out.common_output;
         end
      end
      chk("mux lines", 16'd15, 16'(n));
      for (int k = 0; k < 3; k++) begin
         cmd(8'hb1, phs[k], 8'h00, 1);
         wait_line;
         while (scan_out.valid) begin
            @(posedge mclk_in);
            #1;
         end
         n = 0;
         while (!scan_out.valid) begin
            @(posedge mclk_in);
            #1;
            n++;
         end
         chk("phase gap", 16'(2 * phs[k][3:0] + phs[k][7:4]), 16'(n));
      end
      cmd(8'hae, 8'h00, 8'h00, 0);
      repeat (3) @(posedge mclk_in);
      #1 chk("panel off", 16'h0, {seg_enable_out, common_oe_out});
      summarize;
   end
endmodule // matrix_scan_mapping_config_bench
